// File: src/adc_trig_ctrl.sv
// Converter trigger source selection and channel interrupt enables.
// Assumes one AHB-Lite master, hready tied to this slave's hreadyout.
//
// How it works
// - Low enable bits allow or suppress channel 0-15 interrupts.
// - High enable bits 5-0 gate channel 16-21 interrupts likewise.
// - High enable bits 15-6 ignore writes and read zero.
// - Each input has a 5-bit trigger field, register bits 4-0 or 12-8.
// - Codes 0 none, 1 common soft, 2 level soft, 3 reserved.
// - Code 4 PWM special event, 5-10 PWM primary triggers 1-6.
// - Code 11 logic cell one, code 21 logic cell two.
// - Code 12 timer 1 period, code 13 timer 2 period.
// - Code 14 PWM secondary special, 15-20 PWM secondary 1-6.
// - Codes 22 and 23 select output compare 1 and 2.
// - Codes 24-29 select PWM current-limit triggers 1-6.
// - Code 30 pattern generator output 30, 31 external pin.
`timescale 1ns/10ps
module adc_trig_ctrl (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Trigger events
  input wire logic pwm_special_evt_i,
  input wire logic [5:0] pwm_pri_trig_i,
  input wire logic logic_cell_one_output_i,
  input wire logic tmr1_period_i,
  input wire logic tmr2_period_i,
  input wire logic pwm_sec_special_evt_i,
  input wire logic [5:0] pwm_sec_trig_i,
  input wire logic logic_cell_two_output_i,
  input wire logic oc1_trig_i,
  input wire logic oc2_trig_i,
  input wire logic [5:0] pwm_clim_trig_i,
  input wire logic pattern_trigger_generator_i,
  input wire logic external_conversion_trigger_in_i,
  // Conversion datapath
  input wire logic [21:0] conv_done_i,
  output logic [21:0] conv_req_o,
  // Interrupts
  output logic [21:0] chan_irq_o,
  output logic irq_o
);

  logic [15:0] ie_low_r;
  logic [5:0] ie_high_r;
  logic [4:0] trig_sel_r [adc_trig_pkg::NUM_CH];
  logic sw_level_r;
  logic sw_common_r;
  logic ext_pin_r;
  logic ext_rise;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic accept;
  logic rd_accept;
  logic wr_do;
  logic clr_stat_low;
  logic clr_stat_high;
  logic [15:0] stat_low;
  logic [5:0] stat_high;
  logic [21:0] ie_all;
  logic [21:0] stat_all;
  logic [31:0] events;
  logic [21:0] req;
  logic [31:0] rdata_nxt;

  function automatic logic [7:0] trig_addr(input logic [7:0] base,
                                           input int x);
    logic [7:0] step;
    step = 8'(x) * adc_trig_pkg::TRIG_REG_STRIDE;
    return 8'(base + step);
  endfunction

  // Bus transfer decode
  assign accept = hsel_i & hready_i & htrans_i[1];
  assign rd_accept = accept & ~hwrite_i;
  assign wr_do = wr_pend_r;
  assign clr_stat_low = rd_accept && haddr_i == adc_trig_pkg::OFF_STAT_LOW;
  assign clr_stat_high = rd_accept &&
                         haddr_i == adc_trig_pkg::OFF_STAT_HIGH;

  // Write data phase: one wait state, data written in that cycle
  // Response is always OKAY
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= adc_trig_pkg::HRESP_OKAY[0];
    end
    else if (ce_i)
    begin
      hresp_o <= adc_trig_pkg::HRESP_OKAY[0];
      if (wr_pend_r)
      begin
        wr_pend_r <= 1'b0;
        hreadyout_o <= 1'b1;
      end
      else if (accept && hwrite_i)
      begin
        wr_pend_r <= 1'b1;
        wr_addr_r <= haddr_i;
        hreadyout_o <= 1'b0;
      end
    end
  end

  // Interrupt enable registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ie_low_r <= adc_trig_pkg::IE_LOW_RESET;
      ie_high_r <= adc_trig_pkg::IE_HIGH_RESET;
    end
    else if (ce_i && wr_do)
    begin
      if (wr_addr_r == adc_trig_pkg::OFF_IE_LOW)
      begin
        ie_low_r <= hwdata_i[15:0];
      end
      if (wr_addr_r == adc_trig_pkg::OFF_IE_HIGH)
      begin
        ie_high_r <= hwdata_i[5:0];
      end
    end
  end

  // Software trigger control and external pin history
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sw_level_r <= 1'b0;
      sw_common_r <= 1'b0;
      ext_pin_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_pin_r <= external_conversion_trigger_in_i;
      if (wr_do && wr_addr_r == adc_trig_pkg::OFF_CTRL)
      begin
        sw_level_r <= hwdata_i[adc_trig_pkg::CTRL_SW_LEVEL_BIT];
        sw_common_r <= hwdata_i[adc_trig_pkg::CTRL_SW_COMMON_BIT];
      end
      else
      begin
        sw_common_r <= 1'b0;
      end
    end
  end

  // Trigger source fields, two inputs per register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < adc_trig_pkg::NUM_CH; i++)
      begin
        trig_sel_r[i] <= adc_trig_pkg::TRIG_RESET;
      end
    end
    else if (ce_i && wr_do)
    begin
      for (int x = 0; x < adc_trig_pkg::NUM_TRIG_REG; x++)
      begin
        if (wr_addr_r == trig_addr(adc_trig_pkg::OFF_TRIG_LOW_BASE, x))
        begin
          trig_sel_r[4*x] <=
            hwdata_i[adc_trig_pkg::FLD_A_LSB +: adc_trig_pkg::TRIG_W];
          trig_sel_r[4*x+1] <=
            hwdata_i[adc_trig_pkg::FLD_B_LSB +: adc_trig_pkg::TRIG_W];
        end
        if (wr_addr_r == trig_addr(adc_trig_pkg::OFF_TRIG_HIGH_BASE, x) &&
            4*x+2 < adc_trig_pkg::NUM_CH)
        begin
          trig_sel_r[4*x+2] <=
            hwdata_i[adc_trig_pkg::FLD_A_LSB +: adc_trig_pkg::TRIG_W];
          trig_sel_r[4*x+3] <=
            hwdata_i[adc_trig_pkg::FLD_B_LSB +: adc_trig_pkg::TRIG_W];
        end
      end
    end
  end

  // External pin rising edge
  assign ext_rise = external_conversion_trigger_in_i & ~ext_pin_r;

  // Event vector indexed by trigger code
  always_comb
  begin
    events = '0;
    events[adc_trig_pkg::TRG_SW_COMMON] = sw_common_r;
    events[adc_trig_pkg::TRG_SW_LEVEL] = sw_level_r;
    events[adc_trig_pkg::TRG_PWM_SPECIAL] = pwm_special_evt_i;
    for (int g = 0; g < adc_trig_pkg::NUM_PWM_GEN; g++)
    begin
      events[int'(adc_trig_pkg::TRG_PWM_PRI1) + g] =
        pwm_pri_trig_i[g];
      events[int'(adc_trig_pkg::TRG_PWM_SEC1) + g] =
        pwm_sec_trig_i[g];
      events[int'(adc_trig_pkg::TRG_PWM_CLIM1) + g] =
        pwm_clim_trig_i[g];
    end
    events[adc_trig_pkg::TRG_LOGIC_CELL_ONE] =
      logic_cell_one_output_i;
    events[adc_trig_pkg::TRG_LOGIC_CELL_TWO] =
      logic_cell_two_output_i;
    events[adc_trig_pkg::TRG_TMR1_PERIOD] = tmr1_period_i;
    events[adc_trig_pkg::TRG_TMR2_PERIOD] = tmr2_period_i;
    events[adc_trig_pkg::TRG_PWM_SEC_SPECIAL] =
      pwm_sec_special_evt_i;
    events[adc_trig_pkg::TRG_OC1] = oc1_trig_i;
    events[adc_trig_pkg::TRG_OC2] = oc2_trig_i;
    events[adc_trig_pkg::TRG_PATTERN_OUT30] =
      pattern_trigger_generator_i;
    events[adc_trig_pkg::TRG_EXT_PIN] = ext_rise;
  end

  // One selector per analog input
  genvar ch;
  generate
    for (ch = 0; ch < adc_trig_pkg::NUM_CH; ch++)
    begin : g_sel
      trig_select u_sel (
        .code_i(trig_sel_r[ch]),
        .events_i(events),
        .req_o(req[ch])
      );
    end
  endgenerate

  // Registered conversion requests
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      conv_req_o <= '0;
    end
    else if (ce_i)
    begin
      conv_req_o <= req;
    end
  end

  // Sticky conversion-done status, cleared by reading it
  irq_sticky_bits #(
    .W(adc_trig_pkg::IE_LOW_W)
  ) u_stat_low (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .set_i(conv_done_i[15:0]),
    .clr_i(clr_stat_low),
    .status_o(stat_low)
  );

  irq_sticky_bits #(
    .W(adc_trig_pkg::IE_HIGH_W)
  ) u_stat_high (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .set_i(conv_done_i[21:16]),
    .clr_i(clr_stat_high),
    .status_o(stat_high)
  );

  assign ie_all = {ie_high_r, ie_low_r};
  assign stat_all = {stat_high, stat_low};

  // Individual and common interrupts gated by the enables
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chan_irq_o <= '0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      chan_irq_o <= stat_all & ie_all;
      irq_o <= |(stat_all & ie_all);
    end
  end

  // Read mux; unmapped and unimplemented bits read zero
  always_comb
  begin
    rdata_nxt = '0;
    unique case (haddr_i)
      adc_trig_pkg::OFF_IE_LOW:
      begin
        rdata_nxt[15:0] = ie_low_r;
      end
      adc_trig_pkg::OFF_IE_HIGH:
      begin
        rdata_nxt[5:0] = ie_high_r;
      end
      adc_trig_pkg::OFF_STAT_LOW:
      begin
        rdata_nxt[15:0] = stat_low;
      end
      adc_trig_pkg::OFF_STAT_HIGH:
      begin
        rdata_nxt[5:0] = stat_high;
      end
      adc_trig_pkg::OFF_CTRL:
      begin
        rdata_nxt[adc_trig_pkg::CTRL_SW_LEVEL_BIT] = sw_level_r;
      end
      default:
      begin
        for (int x = 0; x < adc_trig_pkg::NUM_TRIG_REG; x++)
        begin
          if (haddr_i == trig_addr(adc_trig_pkg::OFF_TRIG_LOW_BASE, x))
          begin
            rdata_nxt[adc_trig_pkg::FLD_A_LSB +: adc_trig_pkg::TRIG_W] =
              trig_sel_r[4*x];
            rdata_nxt[adc_trig_pkg::FLD_B_LSB +: adc_trig_pkg::TRIG_W] =
              trig_sel_r[4*x+1];
          end
          if (haddr_i == trig_addr(adc_trig_pkg::OFF_TRIG_HIGH_BASE, x) &&
              4*x+2 < adc_trig_pkg::NUM_CH)
          begin
            rdata_nxt[adc_trig_pkg::FLD_A_LSB +: adc_trig_pkg::TRIG_W] =
              trig_sel_r[4*x+2];
            rdata_nxt[adc_trig_pkg::FLD_B_LSB +: adc_trig_pkg::TRIG_W] =
              trig_sel_r[4*x+3];
          end
        end
      end
    endcase
  end

  // Read data captured at the address phase
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_o <= adc_trig_pkg::RDATA_RESET;
    end
    else if (ce_i && rd_accept)
    begin
      hrdata_o <= rdata_nxt;
    end
  end

endmodule

// File: pkg/adc_trig_pkg.sv
// Constants for the converter trigger and interrupt enable block.
// Assumes a single AHB-Lite slave decode on the low address byte.
package adc_trig_pkg;

  // Geometry
  localparam int NUM_CH = 22;
  localparam int TRIG_W = 5;
  localparam int NUM_EVT = 32;
  localparam int NUM_TRIG_REG = 6;
  localparam int IE_LOW_W = 16;
  localparam int IE_HIGH_W = 6;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_IE_LOW = 8'h00;
  localparam logic [7:0] OFF_IE_HIGH = 8'h04;
  localparam logic [7:0] OFF_STAT_LOW = 8'h08;
  localparam logic [7:0] OFF_STAT_HIGH = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_TRIG_LOW_BASE = 8'h20;
  localparam logic [7:0] OFF_TRIG_HIGH_BASE = 8'h40;
  localparam logic [7:0] TRIG_REG_STRIDE = 8'h04;

  // Field positions
  localparam int FLD_A_LSB = 0;
  localparam int FLD_B_LSB = 8;
  localparam int CTRL_SW_COMMON_BIT = 0;
  localparam int CTRL_SW_LEVEL_BIT = 1;

  // Reset values
  localparam logic [15:0] IE_LOW_RESET = 16'h0000;
  localparam logic [5:0] IE_HIGH_RESET = 6'h00;
  localparam logic [4:0] TRIG_RESET = 5'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // Trigger source codes
  typedef enum logic [4:0] {
    TRG_NONE = 5'b00000,
    TRG_SW_COMMON = 5'b00001,
    TRG_SW_LEVEL = 5'b00010,
    TRG_RESERVED = 5'b00011,
    TRG_PWM_SPECIAL = 5'b00100,
    TRG_PWM_PRI1 = 5'b00101,
    TRG_LOGIC_CELL_ONE = 5'b01011,
    TRG_TMR1_PERIOD = 5'b01100,
    TRG_TMR2_PERIOD = 5'b01101,
    TRG_PWM_SEC_SPECIAL = 5'b01110,
    TRG_PWM_SEC1 = 5'b01111,
    TRG_LOGIC_CELL_TWO = 5'b10101,
    TRG_OC1 = 5'b10110,
    TRG_OC2 = 5'b10111,
    TRG_PWM_CLIM1 = 5'b11000,
    TRG_PATTERN_OUT30 = 5'b11110,
    TRG_EXT_PIN = 5'b11111
  } trig_src_e;

  localparam int NUM_PWM_GEN = 6;

endpackage

// File: src/trig_select.sv
// One trigger source selector: picks one event line by its 5-bit code.
// Assumes the event vector already holds zero at the unused codes.
`timescale 1ns/10ps
module trig_select (
  // Selection
  input wire logic [4:0] code_i,
  // Candidate events, indexed by code
  input wire logic [31:0] events_i,
  // Conversion request for this input
  output logic req_o
);

  always_comb
  begin
    // No-trigger and reserved codes never request
    if (code_i == adc_trig_pkg::TRG_NONE ||
        code_i == adc_trig_pkg::TRG_RESERVED)
    begin
      req_o = 1'b0;
    end
    else
    begin
      req_o = events_i[code_i];
    end
  end

endmodule

// File: src/irq_sticky_bits.sv
// Sticky status bits set by events and cleared by a register read.
// Assumes clear is a one-cycle pulse from the bus read decode.
`timescale 1ns/10ps
module irq_sticky_bits #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Events and clear
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  // Status
  output logic [W-1:0] status_o
);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      status_o <= '0;
    end
    else if (ce_i)
    begin
      // Set wins over a clear in the same cycle
      if (clr_i)
      begin
        status_o <= set_i;
      end
      else
      begin
        status_o <= status_o | set_i;
      end
    end
  end

endmodule

// File: test/adc_trig_chk.sv
// Checker for the trigger selection and interrupt enable block.
// Assumes hready_i is tied to hreadyout_o; ce_i drops only off the bus.
`timescale 1ns/10ps
module adc_trig_chk (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Converter and interrupts
  input wire logic [21:0] conv_done_i,
  input wire logic [21:0] conv_req_o,
  input wire logic [21:0] chan_irq_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic acc;
  logic rd;
  logic wr;
  logic trig_seen_r;
  assign acc = ce_i & hsel_i & hready_i & htrans_i[1];
  assign rd = acc & ~hwrite_i;
  assign wr = acc & hwrite_i;
  // Set once software has written any trigger field
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      trig_seen_r <= 1'b0;
    else if (wr && haddr_i >= 8'h20)
      trig_seen_r <= 1'b1;
  end
  rst_quiet_a: assert property (disable iff (1'b0)
    sys_rst_i |=> conv_req_o == '0 && chan_irq_o == '0 && !irq_o)
    else $error("outputs not quiet after reset");
  ie_high_zero_a: assert property (
    rd && haddr_i == adc_trig_pkg::OFF_IE_HIGH |=> hrdata_o[31:6] == '0)
    else $error("enable high upper bits not zero");
  trig_read_zero_a: assert property (
    rd && haddr_i[7:5] == 3'h1 && haddr_i[4:0] <= 5'h14
    |=> hrdata_o[31:13] == '0 && hrdata_o[7:5] == '0)
    else $error("trigger register spare bits not zero");
  req_needs_field_a: assert property (
    conv_req_o != '0 |-> trig_seen_r)
    else $error("request with no trigger field set");
  stat_low_clear_a: assert property (
    rd && haddr_i == adc_trig_pkg::OFF_STAT_LOW && conv_done_i[15:0] == '0
    |-> ##2 chan_irq_o[15:0] == '0)
    else $error("low channel interrupt kept after clear");
  stat_high_clear_a: assert property (
    rd && haddr_i == adc_trig_pkg::OFF_STAT_HIGH &&
    conv_done_i[21:16] == '0 |-> ##2 chan_irq_o[21:16] == '0)
    else $error("high channel interrupt kept after clear");
  irq_common_a: assert property (
    irq_o == (|chan_irq_o))
    else $error("common interrupt differs from channel terms");
  write_wait_a: assert property (
    wr |=> !hreadyout_o ##1 hreadyout_o)
    else $error("write wait state wrong");
  resp_okay_a: assert property (
    acc |=> !hresp_o)
    else $error("response not okay");
  cover property (wr);
  cover property (conv_req_o != '0);
  cover property ($rose(irq_o));
endmodule
bind adc_trig_ctrl adc_trig_chk adc_trig_chk_i (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .conv_done_i(conv_done_i), .conv_req_o(conv_req_o),
  .chan_irq_o(chan_irq_o), .irq_o(irq_o)
);

// File: test/tb_top.sv
// Self-checking bench for the trigger and interrupt enable block.
// Assumes one bus master here and all events driven by this bench.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] evt = 32'h0;
  logic [21:0] done = 22'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [21:0] req;
  logic [21:0] chan_irq;
  logic irq;
  logic [31:0] rd;
  int miscompares = 0;
  int compares = 0;
  int n0;
  int n21;

  adc_trig_ctrl adc_trig_ctrl_i (
    .ref_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .pwm_special_evt_i(evt[4]), .pwm_pri_trig_i(evt[10:5]),
    .logic_cell_one_output_i(evt[11]), .tmr1_period_i(evt[12]),
    .tmr2_period_i(evt[13]), .pwm_sec_special_evt_i(evt[14]),
    .pwm_sec_trig_i(evt[20:15]), .logic_cell_two_output_i(evt[21]),
    .oc1_trig_i(evt[22]), .oc2_trig_i(evt[23]),
    .pwm_clim_trig_i(evt[29:24]), .pattern_trigger_generator_i(evt[30]),
    .external_conversion_trigger_in_i(evt[31]), .conv_done_i(done),
    .conv_req_o(req), .chan_irq_o(chan_irq), .irq_o(irq)
  );

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic pulse(input logic [31:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 32'h0;
  endtask

  // Counts requests of inputs 0 and 21 over five cycles
  task automatic count;
    n0 = 0;
    n21 = 0;
    repeat (5)
    begin
      @(negedge clk);
      n0 += (req[0] === 1'b1);
      n21 += (req[21] === 1'b1);
      chk("other inputs", 32'h0, {12'h0, req[20:1]});
    end
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("ie low reset", 8'h00, 32'h0);
    rdc("ie high reset", 8'h04, 32'h0);
    rdc("trig reset", 8'h20, 32'h0);
    wr(8'h00, 32'hffffffff);
    rdc("ie low", 8'h00, 32'h0000ffff);
    wr(8'h04, 32'hffffffff);
    rdc("ie high", 8'h04, 32'h3f);
    rdc("unmapped", 8'h80, 32'h0);
    for (int c = 0; c < 32; c++)
    begin
      wr(8'h20, c);
      wr(8'h34, c << 8);
      if (c == 0 || c == 3)
      begin
        pulse(32'hffffffff);
        count;
        chk("no trigger", 0, n0 + n21);
        wr(8'h10, 32'h3);
        count;
        chk("no soft trigger", 0, n0 + n21);
        wr(8'h10, 32'h0);
      end
      else if (c < 3)
      begin
        wr(8'h10, c);
        count;
        chk("soft input 0", (c == 1) ? 1 : 5, n0);
        chk("soft input 21", (c == 1) ? 1 : 5, n21);
        wr(8'h10, 32'h0);
        count;
        chk("soft stopped", 0, n0 + n21);
      end
      else
      begin
        pulse(~(32'h1 << c));
        count;
        chk("unselected", 0, n0 + n21);
        pulse(32'h1 << c);
        count;
        chk("input 0", 1, n0);
        chk("input 21", 1, n21);
      end
    end
    rdc("trig field a", 8'h20, 32'h1f);
    rdc("trig field b", 8'h34, 32'h1f00);
    @(posedge clk);
    done <= 22'h3fffff;
    @(posedge clk);
    done <= 22'h0;
    repeat (3) @(negedge clk);
    chk("chan irq all", 32'h3fffff, {10'h0, chan_irq});
    chk("common irq", 32'h1, {31'h0, irq});
    wr(8'h00, 32'h0);
    repeat (2) @(negedge clk);
    chk("chan irq high", 32'h3f0000, {10'h0, chan_irq});
    rdc("status high", 8'h0c, 32'h3f);
    repeat (2) @(negedge clk);
    chk("common irq off", 32'h0, {31'h0, irq});
    rdc("status low kept", 8'h08, 32'hffff);
    wr(8'h00, 32'h20);
    @(posedge clk);
    done <= 22'h30;
    @(posedge clk);
    done <= 22'h0;
    repeat (3) @(negedge clk);
    chk("chan irq bit 5", 32'h20, {10'h0, chan_irq});
    rdc("status low", 8'h08, 32'h30);
    @(posedge clk);
    ce <= 1'b0;
    done <= 22'h20;
    @(posedge clk);
    ce <= 1'b1;
    done <= 22'h0;
    repeat (3) @(negedge clk);
    chk("frozen status", 32'h0, {10'h0, chan_irq});
    test_done;
  end
endmodule
